// file: tmc_capture.sv
/*
  Capture input front end: synchroniser, optional noise filter and edge
  selection. Assumes the capture pin is asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_capture
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic capture_input_pin,
  tmc_ctl_if.cap ctl
);

  logic s1_r;
  logic s2_r;
  logic [NC_SAMPLES-1:0] hist_r;
  logic level_r;
  logic prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      hist_r <= '0;
      level_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      s1_r <= capture_input_pin;
      s2_r <= s1_r;
      hist_r <= {hist_r[NC_SAMPLES-2:0], s2_r};
      prev_r <= level_r;
      if (!ctl.noise_cancel) begin
        level_r <= s2_r;
      end else if (&hist_r || ~|hist_r) begin
        level_r <= hist_r[0];
      end
    end
  end

  wire rise = level_r & ~prev_r;
  wire fall = ~level_r & prev_r;

  // Edges seen while disconnected are dropped, not held back
  assign ctl.cap_event = ctl.capture_enable & (ctl.edge_select ? rise : fall);

endmodule

`default_nettype wire

// file: tmc_ctl_if.sv
/*
  Interface joining the timer control core to its prescaler and its
  capture front end. Assumes one clock domain, pclk.
*/
`timescale 1ns/1ps
`default_nettype none

interface tmc_ctl_if;
  logic [2:0] clock_select;
  logic noise_cancel;
  logic edge_select;
  logic capture_enable;
  logic tick;
  logic cap_event;
  modport core(output clock_select, noise_cancel, edge_select, capture_enable, input tick, cap_event);
  modport pre(input clock_select, output tick);
  modport cap(input noise_cancel, edge_select, capture_enable, output cap_event);
endinterface

`default_nettype wire

// file: tmc_pin_model.sv
/*
  Model of the capture pin and external clock pin sources.
  Assumes the bench calls its tasks; pins move just after pclk edges.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_model (
  input wire logic pclk,
  output var logic capture_input_pin,
  output var logic external_clock_pin
);
  initial begin
    capture_input_pin = 1'b0;
    external_clock_pin = 1'b0;
  end

  task automatic set_cap(input logic v);
    @(posedge pclk);
    capture_input_pin <= v;
  endtask

  task automatic set_ext(input logic v);
    @(posedge pclk);
    external_clock_pin <= v;
  endtask

  // Slow edges: each level holds long enough to clear the synchroniser
  task automatic ext_pulse(input int n, input int half);
    repeat (n) begin
      set_ext(1'b1);
      repeat (half) @(posedge pclk);
      set_ext(1'b0);
      repeat (half) @(posedge pclk);
    end
  endtask
endmodule

`default_nettype wire

// file: tmc_pkg.sv
/*
  Constants, types and the waveform mode decoder of the 16-bit timer
  control block. Assumes an APB register bus with 32-bit data.
*/
// Behaviour
// - Mode 0: normal counting, TOP 0xFFFF, immediate compare update, overflow at MAX.
// - Modes 1-3: phase correct PWM, TOP 0x00FF/0x01FF/0x03FF, update TOP, flag BOTTOM.
// - Mode 4: clear on compare, TOP compare A, immediate update, overflow at MAX.
// - Modes 5-7: fast PWM, fixed 8/9/10-bit TOP, update BOTTOM, flag at TOP.
// - Modes 8, 9: phase/frequency correct, TOP capture or compare A, all at BOTTOM.
// - Modes 10, 11: phase correct, TOP capture or compare A, update TOP, flag BOTTOM.
// - Mode 12: clear on compare, TOP capture register, immediate update, overflow at MAX.
// - Modes 14, 15: fast PWM, TOP capture or compare A, update BOTTOM, flag TOP.
// - Control B: upper mode bits at 4 and 3, clock select 2:0, bit 5 unused.
// - Control A bits 1:0 are the lower mode bits of the four-bit mode.
// - Noise cancel: capture input changes only after four equal samples.
// - Edge select 0 captures on falling edge, 1 on rising edge.
// - Capture edge copies counter into capture register and sets capture flag.
// - While the capture register is TOP, the capture input is disconnected.
// - Clock select 0-5: stopped, undivided, /8, /64, /256, /1024.
// - Clock select 6 and 7: external pin, falling or rising edge.

`default_nettype none

package tmc_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL_A = 8'h90;
  localparam logic [7:0] IDX_CTRL_B = 8'h91;
  localparam logic [7:0] IDX_COUNT = 8'h94;
  localparam logic [7:0] IDX_CAPTURE = 8'h96;
  localparam logic [7:0] IDX_COMPARE_A = 8'h98;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hA1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hA2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CB_NOISE_BIT = 7;
  localparam int CB_EDGE_BIT = 6;
  localparam int CB_WGM_HI = 4;
  localparam int CB_WGM_LO = 3;
  localparam int CB_CS_HI = 2;
  localparam int CB_CS_LO = 0;
  localparam int CA_WGM_HI = 1;
  localparam int CA_WGM_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CAP_BIT = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // Counter limits, clock select codes, prescaler taps
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_TAP8 = 3;
  localparam int PRE_TAP64 = 6;
  localparam int PRE_TAP256 = 8;
  localparam int PRE_TAP1024 = 10;
  localparam int NC_SAMPLES = 4;

  typedef enum logic [1:0] {SEQ_UP, SEQ_DUAL, SEQ_CLEAR} tmc_seq_e;
  typedef enum logic [2:0] {TOP_FULL, TOP_B8, TOP_B9, TOP_B10, TOP_CAP, TOP_CMPA} tmc_top_e;
  typedef enum logic [1:0] {UPD_IMM, UPD_TOP, UPD_BOTTOM} tmc_upd_e;
  typedef enum logic [1:0] {OVF_MAX, OVF_TOP, OVF_BOTTOM} tmc_ovf_e;

  typedef struct packed {
    tmc_seq_e seq;
    tmc_top_e top;
    tmc_upd_e upd;
    tmc_ovf_e ovf;
  } tmc_mode_s;

  function automatic tmc_mode_s tmc_decode(input logic [3:0] m);
    tmc_mode_s d;
    d = '{SEQ_UP, TOP_FULL, UPD_IMM, OVF_MAX};
    unique case (m)
      4'h0: d = '{SEQ_UP, TOP_FULL, UPD_IMM, OVF_MAX};
      4'h1: d = '{SEQ_DUAL, TOP_B8, UPD_TOP, OVF_BOTTOM};
      4'h2: d = '{SEQ_DUAL, TOP_B9, UPD_TOP, OVF_BOTTOM};
      4'h3: d = '{SEQ_DUAL, TOP_B10, UPD_TOP, OVF_BOTTOM};
      4'h4: d = '{SEQ_CLEAR, TOP_CMPA, UPD_IMM, OVF_MAX};
      4'h5: d = '{SEQ_UP, TOP_B8, UPD_BOTTOM, OVF_TOP};
      4'h6: d = '{SEQ_UP, TOP_B9, UPD_BOTTOM, OVF_TOP};
      4'h7: d = '{SEQ_UP, TOP_B10, UPD_BOTTOM, OVF_TOP};
      4'h8: d = '{SEQ_DUAL, TOP_CAP, UPD_BOTTOM, OVF_BOTTOM};
      4'h9: d = '{SEQ_DUAL, TOP_CMPA, UPD_BOTTOM, OVF_BOTTOM};
      4'hA: d = '{SEQ_DUAL, TOP_CAP, UPD_TOP, OVF_BOTTOM};
      4'hB: d = '{SEQ_DUAL, TOP_CMPA, UPD_TOP, OVF_BOTTOM};
      4'hC: d = '{SEQ_CLEAR, TOP_CAP, UPD_IMM, OVF_MAX};
      // Reserved code falls back to plain counting so the state stays defined
      4'hD: d = '{SEQ_UP, TOP_FULL, UPD_IMM, OVF_MAX};
      4'hE: d = '{SEQ_UP, TOP_CAP, UPD_BOTTOM, OVF_TOP};
      4'hF: d = '{SEQ_UP, TOP_CMPA, UPD_BOTTOM, OVF_TOP};
    endcase
    return d;
  endfunction

endpackage

`default_nettype wire

// file: tmc_prescaler.sv
/*
  Clock source selection: prescaled taps of pclk or edges of the
  external clock pin. Assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_prescaler
  import tmc_pkg::*;
#(
  parameter int PRE_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic external_clock_pin,
  tmc_ctl_if.pre ctl
);

  if (PRE_W < PRE_TAP1024) begin : g_chk
    $error("tmc_prescaler: PRE_W too small for the /1024 tap");
  end

  logic [PRE_W-1:0] pre_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_prev_r;

  // ----------------------------------------------------------------
  // Free running divider and pin synchroniser
  // ----------------------------------------------------------------
  // The divider never restarts, so the first tick after a select change
  // may come early by up to one divided period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 1'b1;
      ext_s1_r <= external_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  wire ext_rise = ext_s2_r & ~ext_prev_r;
  wire ext_fall = ~ext_s2_r & ext_prev_r;

  assign ctl.tick = (ctl.clock_select == CS_DIV1) ? 1'b1 :
                    (ctl.clock_select == CS_DIV8) ? &pre_r[PRE_TAP8-1:0] :
                    (ctl.clock_select == CS_DIV64) ? &pre_r[PRE_TAP64-1:0] :
                    (ctl.clock_select == CS_DIV256) ? &pre_r[PRE_TAP256-1:0] :
                    (ctl.clock_select == CS_DIV1024) ? &pre_r[PRE_TAP1024-1:0] :
                    (ctl.clock_select == CS_EXT_FALL) ? ext_fall :
                    (ctl.clock_select == CS_EXT_RISE) ? ext_rise : 1'b0;

endmodule

`default_nettype wire

// file: tmc_timer_ctrl.sv
/*
  Top of the 16-bit timer control block: APB register file, mode decode,
  TOP selection, counter sequencing, compare update point, overflow and
  capture flags with one level interrupt. Assumes an APB3 master on pclk
  and asynchronous capture and external clock pins.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tmc_timer_ctrl
  import tmc_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int PRE_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_pin,
  input wire logic external_clock_pin,
  output logic irq,
  output logic [3:0] waveform_mode,
  output logic [15:0] top_value,
  output logic [15:0] count_value,
  output logic count_down,
  output logic compare_update,
  output logic capture_event
);

  if (ADDR_W < 10) begin : g_chk
    $error("tmc_timer_ctrl: ADDR_W must reach byte address 0x288");
  end

  tmc_ctl_if ctl ();

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] wgm_lo_r;
  logic [7:0] ctrl_b_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic down_r;
  logic down_nxt;
  logic [15:0] cap_r;
  logic [15:0] cmpa_buf_r;
  logic [15:0] cmpa_r;
  logic [IRQ_W-1:0] sts_r;
  logic [IRQ_W-1:0] sts_nxt;
  logic [IRQ_W-1:0] ena_r;
  logic [31:0] prdata_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [7:0] idx = paddr[9:2];
  wire hit_a = (idx == IDX_CTRL_A);
  wire hit_b = (idx == IDX_CTRL_B);
  wire hit_cnt = (idx == IDX_COUNT);
  wire hit_cap = (idx == IDX_CAPTURE);
  wire hit_cmp = (idx == IDX_COMPARE_A);
  wire hit_sts = (idx == IDX_IRQ_STATUS);
  wire hit_clr = (idx == IDX_IRQ_CLEAR);
  wire hit_ena = (idx == IDX_IRQ_ENABLE);
  wire upper_zero = (ADDR_W > 10) ? ~|(paddr >> 10) : 1'b1;
  wire hit_any = upper_zero & (paddr[1:0] == 2'b00) &
                 (hit_a | hit_b | hit_cnt | hit_cap | hit_cmp | hit_sts | hit_clr | hit_ena);
  wire access = psel & penable;
  wire wr = access & pwrite & hit_any;
  wire wr_a = wr & hit_a;
  wire wr_b = wr & hit_b;
  wire wr_cnt = wr & hit_cnt;
  wire wr_cap = wr & hit_cap;
  wire wr_cmp = wr & hit_cmp;
  wire wr_clr = wr & hit_clr;
  wire wr_ena = wr & hit_ena;
  wire [15:0] wdata16 = pwdata[15:0];

  // Bit 5 of control B and bits 7:2 of control A read as zero
  wire [7:0] ctrl_b_rd = {ctrl_b_r[CB_NOISE_BIT], ctrl_b_r[CB_EDGE_BIT], 1'b0,
                          ctrl_b_r[CB_WGM_HI:CB_WGM_LO], ctrl_b_r[CB_CS_HI:CB_CS_LO]};
  wire [31:0] rd_mux = hit_a ? {30'h0000_0000, wgm_lo_r} :
                       hit_b ? {24'h00_0000, ctrl_b_rd} :
                       hit_cnt ? {16'h0000, cnt_r} :
                       hit_cap ? {16'h0000, cap_r} :
                       hit_cmp ? {16'h0000, cmpa_r} :
                       hit_sts ? {{(32-IRQ_W){1'b0}}, sts_r} :
                       hit_ena ? {{(32-IRQ_W){1'b0}}, ena_r} : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // Mode decode and TOP selection
  // ----------------------------------------------------------------
  wire [3:0] mode = {ctrl_b_r[CB_WGM_HI:CB_WGM_LO], wgm_lo_r};
  tmc_mode_s md;
  assign md = tmc_decode(mode);

  wire [15:0] top_sel = (md.top == TOP_B8) ? TOP_8BIT :
                        (md.top == TOP_B9) ? TOP_9BIT :
                        (md.top == TOP_B10) ? TOP_10BIT :
                        (md.top == TOP_CAP) ? cap_r :
                        (md.top == TOP_CMPA) ? cmpa_r : CNT_MAX;

  // ----------------------------------------------------------------
  // Counter sequencing
  // ----------------------------------------------------------------
  wire dual = (md.seq == SEQ_DUAL);
  wire at_top = (cnt_r >= top_sel);
  wire at_bot = (cnt_r == CNT_BOTTOM);
  wire tick = ctl.tick;
  wire reach_top = tick & at_top & ~down_r;
  wire reach_bot = tick & (dual ? (down_r & at_bot) : at_top);

  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    if (!dual) begin
      down_nxt = 1'b0;
    end
    if (wr_cnt) begin
      cnt_nxt = wdata16;
    end else if (tick) begin
      if (dual) begin
        if (!down_r && at_top) begin
          down_nxt = 1'b1;
          cnt_nxt = at_bot ? cnt_r : cnt_r - 16'h0001;
        end else if (down_r && at_bot) begin
          down_nxt = 1'b0;
          cnt_nxt = cnt_r + 16'h0001;
        end else begin
          cnt_nxt = down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
        end
      end else begin
        cnt_nxt = at_top ? CNT_BOTTOM : cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overflow point, compare update point, capture
  // ----------------------------------------------------------------
  wire ovf_evt = (md.ovf == OVF_MAX) ? (tick & (cnt_r == CNT_MAX)) :
                 (md.ovf == OVF_TOP) ? (reach_top & ~dual) :
                 reach_bot & dual;
  wire cmp_upd = (md.upd == UPD_IMM) ? wr_cmp :
                 (md.upd == UPD_TOP) ? reach_top : reach_bot;
  wire cap_evt = ctl.cap_event;

  assign ctl.clock_select = ctrl_b_r[CB_CS_HI:CB_CS_LO];
  assign ctl.noise_cancel = ctrl_b_r[CB_NOISE_BIT];
  assign ctl.edge_select = ctrl_b_r[CB_EDGE_BIT];
  assign ctl.capture_enable = (md.top != TOP_CAP);

  // Hardware set wins over a software clear in the same cycle
  wire [IRQ_W-1:0] evt_vec = {cap_evt, ovf_evt};
  always_comb begin
    sts_nxt = sts_r & ~(wr_clr ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}});
    sts_nxt = sts_nxt | evt_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wgm_lo_r <= CTRL_RESET[1:0];
      ctrl_b_r <= CTRL_RESET;
      cnt_r <= WORD_RESET;
      down_r <= 1'b0;
      sts_r <= '0;
      ena_r <= '0;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr_a) begin
        wgm_lo_r <= pwdata[CA_WGM_HI:CA_WGM_LO];
      end
      if (wr_b) begin
        ctrl_b_r <= pwdata[7:0] & 8'hDF;
      end
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
      sts_r <= sts_nxt;
      if (wr_ena) begin
        ena_r <= pwdata[IRQ_W-1:0];
      end
      if (psel && !penable) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // The capture register is also writable so software can set TOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= WORD_RESET;
      cmpa_buf_r <= WORD_RESET;
      cmpa_r <= WORD_RESET;
    end else begin
      if (cap_evt) begin
        cap_r <= cnt_r;
      end else if (wr_cap) begin
        cap_r <= wdata16;
      end
      if (wr_cmp) begin
        cmpa_buf_r <= wdata16;
      end
      if (cmp_upd) begin
        cmpa_r <= (md.upd == UPD_IMM) ? wdata16 : cmpa_buf_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Submodules and outputs
  // ----------------------------------------------------------------
  tmc_prescaler #(
    .PRE_W(PRE_W)
  ) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .external_clock_pin(external_clock_pin),
    .ctl(ctl.pre)
  );

  tmc_capture u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .capture_input_pin(capture_input_pin),
    .ctl(ctl.cap)
  );

  assign irq = |(sts_r & ena_r);
  assign waveform_mode = mode;
  assign top_value = top_sel;
  assign count_value = cnt_r;
  assign count_down = down_r;
  assign compare_update = cmp_upd;
  assign capture_event = cap_evt;

endmodule

`default_nettype wire

// file: tmc_timer_ctrl_checker.sv
/*
  Concurrent checks on the ports of the timer control top.
  Assumes one pclk domain and the register map of tmc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_timer_ctrl_checker
  import tmc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic capture_input_pin,
  input wire logic [3:0] waveform_mode,
  input wire logic [15:0] top_value,
  input wire logic [15:0] count_value,
  input wire logic count_down,
  input wire logic compare_update,
  input wire logic capture_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire wr_access = psel && penable && pwrite;
  wire wr_ctrl_a = wr_access && (paddr == ADDR_W'({IDX_CTRL_A, 2'b00}));
  wire wr_ctrl_b = wr_access && (paddr == ADDR_W'({IDX_CTRL_B, 2'b00}));
  wire wr_count = wr_access && (paddr == ADDR_W'({IDX_COUNT, 2'b00}));
  wire wr_compare = wr_access && (paddr == ADDR_W'({IDX_COMPARE_A, 2'b00}));

  // --------------------------------------------------------------
  // Cycles since the capture pin last moved, saturating
  // --------------------------------------------------------------
  logic [3:0] quiet_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_r <= 4'hF;
    end else if ($changed(capture_input_pin)) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  mode_zero_top_a: assert property (waveform_mode == 4'h0 |-> top_value == 16'hFFFF)
    else $error("top value wrong in normal mode");
  fixed_top_a: assert property (waveform_mode inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}
    |-> top_value == (16'h0080 << waveform_mode[1:0]) - 16'h0001)
    else $error("fixed top value wrong");
  compare_top_a: assert property (wr_compare && waveform_mode == 4'h4 |=> top_value == $past(pwdata[15:0]))
    else $error("compare A not used as top");
  immediate_update_a: assert property (wr_compare && waveform_mode inside {4'h0, 4'h4, 4'hC}
    |-> ##[0:1] compare_update)
    else $error("compare A not loaded on write");
  single_slope_a: assert property ((waveform_mode inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF})[*2]
    |-> !count_down)
    else $error("down count in single slope mode");
  count_step_a: assert property (!$past(wr_count) && $changed(count_value) |->
    count_value == $past(count_value) + 16'h0001 || count_value == $past(count_value) - 16'h0001
    || count_value == 16'h0000)
    else $error("counter jumped");
  capture_off_a: assert property ((waveform_mode inside {4'h8, 4'hA, 4'hC, 4'hE})[*8] |-> !capture_event)
    else $error("capture while capture is top");
  capture_delay_a: assert property (capture_event |-> quiet_r < 4'hA)
    else $error("capture event without pin edge");
  mode_high_a: assert property (wr_ctrl_b |=> waveform_mode[3:2] == $past(pwdata[4:3]))
    else $error("upper mode bits not stored");
  mode_low_a: assert property (wr_ctrl_a |=> waveform_mode[1:0] == $past(pwdata[1:0]))
    else $error("lower mode bits not stored");
endmodule

bind tmc_timer_ctrl tmc_timer_ctrl_checker #(.ADDR_W(ADDR_W)) u_checker (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .capture_input_pin(capture_input_pin), .waveform_mode(waveform_mode), .top_value(top_value),
  .count_value(count_value), .count_down(count_down), .compare_update(compare_update),
  .capture_event(capture_event));

`default_nettype wire

// file: tmc_timer_ctrl_test.sv
/*
  Self-checking bench of the timer control top over APB.
  Assumes the pin model drives both pins and pclk at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_timer_ctrl_test
  import tmc_pkg::*;
;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

  localparam logic [9:0] A_CA = {IDX_CTRL_A, 2'b00};
  localparam logic [9:0] A_CB = {IDX_CTRL_B, 2'b00};
  localparam logic [9:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [9:0] A_CAP = {IDX_CAPTURE, 2'b00};
  localparam logic [9:0] A_CMP = {IDX_COMPARE_A, 2'b00};
  localparam logic [9:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_CLR = {IDX_IRQ_CLEAR, 2'b00};
  localparam logic [9:0] A_EN = {IDX_IRQ_ENABLE, 2'b00};
  localparam logic [15:0] CMPA_V = 16'h0567;
  localparam logic [15:0] CAP_V = 16'h1234;
  localparam int PW = 4096;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, count_down, compare_update, capture_event;
  logic capture_input_pin, external_clock_pin, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] waveform_mode;
  logic [15:0] top_value, count_value;
  int compares, mismatches, cycles, n;
  int sh[6] = '{0, 0, 3, 6, 8, 10};

  tmc_timer_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(capture_input_pin), .external_clock_pin(external_clock_pin), .irq(irq),
    .waveform_mode(waveform_mode), .top_value(top_value), .count_value(count_value), .count_down(count_down),
    .compare_update(compare_update), .capture_event(capture_event));
  tmc_pin_model pins (.pclk(pclk), .capture_input_pin(capture_input_pin), .external_clock_pin(external_clock_pin));

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_rd(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rv, e)
  endtask

  // Ends between edges so that register outputs have settled
  task automatic wait_clk(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask

  function automatic logic [15:0] exp_top(input int m);
    case (m)
      0: return 16'hFFFF;
      1, 5: return 16'h00FF;
      2, 6: return 16'h01FF;
      3, 7: return 16'h03FF;
      8, 10, 12, 14: return CAP_V;
      default: return CMPA_V;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(A_CB, 32'h0000_0000);
    wr(A_CB, 32'h0000_0020);
    chk_rd(A_CB, 32'h0000_0000);
    chk_rd(10'h3FC, 32'h0000_0000);
    `CHK(err, 1'b1)
    wr(A_CMP, 32'(CMPA_V));
    wr(A_CAP, 32'(CAP_V));
    for (int m = 0; m < 16; m++) begin
      if (m == 13) continue;
      wr(A_CA, 32'(m[1:0]));
      wr(A_CB, 32'({m[3:2], 3'b000}));
      wr(A_CMP, 32'(CMPA_V));
      wait_clk(1);
      `CHK(waveform_mode, m[3:0])
      `CHK(top_value, exp_top(m))
    end
    wr(A_CA, 32'h0000_0000);
    for (int c = 0; c < 6; c++) begin
      wr(A_CB, 32'h0000_0000);
      wr(A_CNT, 32'h0000_0000);
      wr(A_CB, 32'(c));
      wait_clk(PW);
      wr(A_CB, 32'h0000_0000);
      apb(1'b0, A_CNT, 32'h0000_0000);
      n = (c == 0) ? 0 : (PW >> sh[c]);
      `CHK((c == 0) ? (rv[15:0] == 16'h0000) : (rv[15:0] + 16'h0001 >= 16'(n) && rv[15:0] <= 16'(n + 4)), 1'b1)
    end
    for (int c = 6; c < 8; c++) begin
      wr(A_CNT, 32'h0000_0000);
      wr(A_CB, 32'(c));
      pins.ext_pulse(3, 4);
      pins.set_ext(1'b1);
      wait_clk(8);
      wr(A_CB, 32'h0000_0000);
      pins.set_ext(1'b0);
      chk_rd(A_CNT, 32'(3 + (c == 7)));
    end
    // Dual slope: turns at TOP, flag only when BOTTOM is reached
    wr(A_CA, 32'h0000_0001);
    wr(A_CNT, 32'h0000_00FA);
    wr(A_CLR, 32'h0000_0003);
    wr(A_CB, 32'h0000_0001);
    wait_clk(20);
    `CHK(count_down, 1'b1)
    chk_rd(A_ST, 32'h0000_0000);
    wait_clk(300);
    chk_rd(A_ST, 32'h0000_0001);
    wr(A_CB, 32'h0000_0000);
    wr(A_CA, 32'h0000_0000);
    wr(A_CNT, 32'h0000_FFF0);
    wr(A_EN, 32'h0000_0000);
    wr(A_CLR, 32'h0000_0003);
    wr(A_CB, 32'h0000_0001);
    wait_clk(30);
    chk_rd(A_ST, 32'h0000_0001);
    `CHK(irq, 1'b0)
    wr(A_EN, 32'h0000_0003);
    wait_clk(1);
    `CHK(irq, 1'b1)
    wr(A_CLR, 32'h0000_0001);
    wait_clk(1);
    `CHK(irq, 1'b0)
    wr(A_CA, 32'h0000_0001);
    wr(A_CB, 32'h0000_0008);
    wr(A_CMP, 32'h0000_0042);
    chk_rd(A_CMP, 32'(CMPA_V));
    wr(A_CNT, 32'h0000_00F0);
    wr(A_CLR, 32'h0000_0003);
    wr(A_CB, 32'h0000_0009);
    wait_clk(30);
    chk_rd(A_ST, 32'h0000_0001);
    `CHK(count_value <= 16'h00FF, 1'b1)
    chk_rd(A_CMP, 32'h0000_0042);
    wr(A_CB, 32'h0000_0000);
    wr(A_CA, 32'h0000_0000);
    // Pin levels 1,0,1,0 under rising then falling select
    for (int i = 0; i < 4; i++) begin
      wr(A_CB, (i < 2) ? 32'h0000_0040 : 32'h0000_0000);
      wr(A_CNT, 32'h0000_0A00 + 32'(i));
      wr(A_CLR, 32'h0000_0003);
      pins.set_cap(i % 2 == 0);
      wait_clk(8);
      chk_rd(A_ST, ((i % 2 == 0) == (i < 2)) ? 32'h0000_0002 : 32'h0000_0000);
      if ((i % 2 == 0) == (i < 2)) chk_rd(A_CAP, 32'h0000_0A00 + 32'(i));
    end
    wr(A_CB, 32'h0000_00C0);
    wr(A_CLR, 32'h0000_0003);
    pins.set_cap(1'b1);
    wait_clk(2);
    pins.set_cap(1'b0);
    wait_clk(12);
    chk_rd(A_ST, 32'h0000_0000);
    pins.set_cap(1'b1);
    n = 0;
    while (capture_event !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    `CHK(n >= 6 && n <= 10, 1'b1)
    wr(A_CB, 32'h0000_0058);
    pins.set_cap(1'b0);
    wait_clk(8);
    wr(A_CLR, 32'h0000_0003);
    pins.set_cap(1'b1);
    wait_clk(12);
    chk_rd(A_ST, 32'h0000_0000);
    finish_test();
  end
endmodule

`default_nettype wire
